// ==== scic_core.sv ====
`timescale 1ns/100ps
// Operation
// - Four read/write-back port arrangements, 8/16 bit
// - Registers answer at data addresses 0..31
// - Registers 26..31 form three pointers
// - Byte push decrements, pop increments by one
// - Calls, entry push; returns pop, step two
// - Stack grows downward, pointer marks top
// - Pointer bytes at I/O 0x3D, 0x3E
// - Pointer resets to last SRAM address
// - Core runs on undivided clock
// - Two-operand ALU step in one cycle
// - Fetch overlaps execution, one per clock
// - Own vector; individual and global enables
// - Boot lock bits block interrupts by PC
// - Lower vector wins; reset highest
// - Select bit, fuse relocate vectors to boot
// - Entry clears global enable; return sets it
// - Vectoring or writing one clears flag
// - Disabled flags stay pending, priority order
// - Flagless sources request only while present
// - One main instruction after return first
// - Status register never saved automatically
// - Disable instruction blocks same-cycle interrupt
// - Instruction after enable runs before interrupt
// - Entry takes four cycles; sleep four more
// - Return takes four cycles, pops, sets enable
module scic_core
   import scic_pkg::*;
#(
   parameter int               NIRQ      = 8,
   parameter logic [NIRQ-1:0]  FLAG_TYPE = '1
) (
   input  wire logic          mclk_i,             // Core clock, undivided
   input  wire logic          nrst_i,             // Async reset, active low
   input  wire scic_rf_req_s  rf_req_i,           // Register file request
   output logic [15:0]        rd_a_o,             // Operand A, 16 bits when wide
   output logic [7:0]         rd_b_o,             // Operand B
   input  wire scic_mem_s     ds_i,               // Data-space access
   output logic [7:0]         ds_rdata_o,         // Data-space read data
   output logic               ds_hit_o,           // Last read hit register file
   input  wire scic_ptr_req_s ptr_req_i,          // Pointer addressing request
   output logic [15:0]        ptr_addr_o,         // Effective pointer address
   input  wire logic          io_we_i,            // I/O write strobe
   input  wire logic          io_re_i,            // I/O read strobe
   input  wire logic [5:0]    io_addr_i,          // I/O address
   input  wire logic [7:0]    io_wdata_i,         // I/O write data
   output logic [7:0]         io_rdata_o,         // I/O read data
   input  wire scic_op_e      op_i,               // Stack/enable operation
   input  wire logic [7:0]    push_data_i,        // Byte for single push
   input  wire logic [15:0]   pc_i,               // Return address / current PC
   input  wire logic          instr_done_i,       // Instruction boundary
   input  wire logic          sleep_i,            // Core is asleep
   output scic_mem_s          mem_o,              // Stack memory access
   input  wire logic [7:0]    mem_rdata_i,        // Stack read data, next cycle
   output logic               stall_o,            // Holds fetch and execution
   output logic               vec_valid_o,        // Jump to vector, pulse
   output logic [15:0]        vec_addr_o,         // Vector address
   output logic               pc_load_o,          // Load popped PC, pulse
   output logic [15:0]        ret_pc_o,           // Popped return address
   output logic [15:0]        reset_vec_o,        // Reset vector
   output logic               glob_irq_en_o,      // Global interrupt enable
   output logic [NIRQ-1:0]    flags_o,            // Interrupt flags
   output logic [10:0]        sp_o,               // Stack pointer
   input  wire logic [NIRQ-1:0] irq_evt_i,        // Flag-setting events
   input  wire logic [NIRQ-1:0] irq_lvl_i,        // Flagless conditions
   input  wire logic [NIRQ-1:0] irq_en_i,         // Individual enables
   input  wire logic          flag_clr_we_i,      // Flag write strobe
   input  wire logic [NIRQ-1:0] flag_clr_data_i,  // Ones clear flags
   input  wire logic          vector_table_select_i,  // Vectors in boot
   input  wire logic          boot_reset_fuse_i,      // Reset vector in boot
   input  wire logic          app_section_lock_bit_i, // Application lock
   input  wire logic          boot_section_lock_bit_i,// Boot lock
   input  wire logic [15:0]   boot_start_i        // Boot section start
);
   typedef enum logic [4:0] {
      ST_RUN  = 5'b00001,
      ST_WAKE = 5'b00010,
      ST_ENT  = 5'b00100,
      ST_CALL = 5'b01000,
      ST_RET  = 5'b10000
   } scic_st_e;

   logic [7:0]      rf_ff [RF_DEPTH];
   logic [7:0]      nxt_rf [RF_DEPTH];
   logic [15:0]     rd_a_ff, nxt_rd_a;
   logic [7:0]      rd_b_ff, nxt_rd_b;
   logic [7:0]      ds_rdata_ff, nxt_ds_rdata;
   logic            ds_hit_ff, nxt_ds_hit;
   logic [15:0]     ptr_addr_ff, nxt_ptr_addr;
   logic [7:0]      io_rdata_ff, nxt_io_rdata;
   logic [10:0]     sp_ff, nxt_sp;
   scic_st_e        st_ff, nxt_st;
   logic [1:0]      cnt_ff, nxt_cnt;
   logic            return_from_irq_instr_ff, nxt_return_from_irq_instr;
   logic            glob_ff, nxt_glob;
   logic [NIRQ-1:0] flag_ff, nxt_flag;
   scic_mem_s       mem_ff, nxt_mem;
   logic            vec_valid_ff, nxt_vec_valid;
   logic [15:0]     vec_addr_ff, nxt_vec_addr;
   logic            pc_load_ff, nxt_pc_load;
   logic [15:0]     ret_pc_ff, nxt_ret_pc;
   logic [15:0]     push_pc_ff, nxt_push_pc;
   logic [15:0]     reset_vec_ff, nxt_reset_vec;

   logic [NIRQ-1:0] pend;
   logic [NIRQ-1:0] win;
   logic [15:0]     win_vec;
   logic            any_pend;
   logic            blocked;
   logic            irq_go;
   logic [15:0]     vec_base;

   // Flagless sources are looked at live, so a vanished condition is never taken
   assign pend = ((FLAG_TYPE & flag_ff) | (~FLAG_TYPE & irq_lvl_i)) & irq_en_i;
   assign any_pend = |pend;
   assign vec_base = vector_table_select_i ? boot_start_i : RESET_VEC;
   // Vectors are protected from code in the other section when its lock is programmed
   assign blocked = (app_section_lock_bit_i & vector_table_select_i & (pc_i < boot_start_i))
                  | (boot_section_lock_bit_i & ~vector_table_select_i & (pc_i >= boot_start_i));

   // Lowest index is the lowest vector and wins; slot zero is reset
   always_comb begin
      win = '0;
      win_vec = vec_base;
      for (int i = NIRQ - 1; i >= 0; i--) begin
         if (pend[i]) begin
            win = '0;
            win[i] = 1'b1;
            win_vec = vec_base + VEC_STEP * 16'(i + 1);
         end
      end
   end

   // Taken only at a boundary with no stack or enable operation in the same cycle
   assign irq_go = (st_ff == ST_RUN) & instr_done_i & (op_i == OP_NONE) & glob_ff & any_pend
                 & ~blocked;

   always_comb begin
      for (int i = 0; i < RF_DEPTH; i++) begin
         nxt_rf[i] = rf_ff[i];
      end
      nxt_rd_a = {8'h00, rf_ff[rf_req_i.ra]};
      if (rf_req_i.rd_wide) begin
         nxt_rd_a[15:8] = rf_ff[{rf_req_i.ra[4:1], 1'b1}];
         nxt_rd_a[7:0] = rf_ff[{rf_req_i.ra[4:1], 1'b0}];
      end
      nxt_rd_b = rf_ff[rf_req_i.rb];
      if (rf_req_i.we) begin
         if (rf_req_i.we_wide) begin
            nxt_rf[{rf_req_i.wa[4:1], 1'b0}] = rf_req_i.wd[7:0];
            nxt_rf[{rf_req_i.wa[4:1], 1'b1}] = rf_req_i.wd[15:8];
         end else begin
            nxt_rf[rf_req_i.wa] = rf_req_i.wd[7:0];
         end
      end
      nxt_ds_hit = ds_hit_ff;
      nxt_ds_rdata = ds_rdata_ff;
      if (ds_i.addr < 16'(RF_DEPTH)) begin
         if (ds_i.we) begin
            nxt_rf[ds_i.addr[4:0]] = ds_i.wdata;
         end
         if (ds_i.re) begin
            nxt_ds_rdata = rf_ff[ds_i.addr[4:0]];
            nxt_ds_hit = 1'b1;
         end
      end else if (ds_i.re) begin
         nxt_ds_rdata = 8'h00;
         nxt_ds_hit = 1'b0;
      end
      nxt_ptr_addr = ptr_addr_ff;
      if (ptr_req_i.en) begin
         automatic logic [4:0]  lo = PTR_BASE + {2'b00, ptr_req_i.sel, 1'b0};
         automatic logic [15:0] pv = {rf_ff[lo + 5'h01], rf_ff[lo]};
         automatic logic [15:0] nv = pv;
         unique case (ptr_req_i.mode)
            PM_INC: begin
               nxt_ptr_addr = pv;
               nv = pv + 16'h0001;
            end
            PM_DEC: begin
               nv = pv - 16'h0001;
               nxt_ptr_addr = nv;
            end
            default: begin
               nxt_ptr_addr = pv + {10'h000, ptr_req_i.disp};
            end
         endcase
         nxt_rf[lo] = nv[7:0];
         nxt_rf[lo + 5'h01] = nv[15:8];
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < RF_DEPTH; i++) begin
            rf_ff[i] <= 8'h00;
         end
         rd_a_ff <= 16'h0000;
         rd_b_ff <= 8'h00;
         ds_rdata_ff <= 8'h00;
         ds_hit_ff <= 1'b0;
         ptr_addr_ff <= 16'h0000;
      end else begin
         rf_ff <= nxt_rf;
         rd_a_ff <= nxt_rd_a;
         rd_b_ff <= nxt_rd_b;
         ds_rdata_ff <= nxt_ds_rdata;
         ds_hit_ff <= nxt_ds_hit;
         ptr_addr_ff <= nxt_ptr_addr;
      end
   end

   // Status flags other than the global enable live elsewhere and are never stacked
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sp = sp_ff;
      nxt_return_from_irq_instr = return_from_irq_instr_ff;
      nxt_glob = glob_ff;
      nxt_mem = '0;
      nxt_vec_valid = 1'b0;
      nxt_vec_addr = vec_addr_ff;
      nxt_pc_load = 1'b0;
      nxt_ret_pc = ret_pc_ff;
      nxt_push_pc = push_pc_ff;
      nxt_reset_vec = boot_reset_fuse_i ? boot_start_i : RESET_VEC;
      nxt_io_rdata = io_rdata_ff;
      nxt_flag = irq_evt_i | (flag_ff & ~(flag_clr_we_i ? flag_clr_data_i : '0));
      if (io_re_i) begin
         nxt_io_rdata = (io_addr_i == IO_SP_LOW) ? sp_ff[7:0] :
                        (io_addr_i == IO_SP_HIGH) ? {5'h00, sp_ff[10:8]} : 8'h00;
      end
      if (io_we_i && io_addr_i == IO_SP_LOW) begin
         nxt_sp[7:0] = io_wdata_i;
      end
      if (io_we_i && io_addr_i == IO_SP_HIGH) begin
         nxt_sp[10:8] = io_wdata_i[2:0];
      end
      unique case (st_ff)
         ST_RUN: begin
            if (op_i == OP_CLI) begin
               nxt_glob = 1'b0;
            end else if (op_i == OP_SEI) begin
               nxt_glob = 1'b1;
            end
            if (irq_go) begin
               nxt_glob = 1'b0;
               nxt_flag = (nxt_flag & ~(win & FLAG_TYPE)) | irq_evt_i;
               nxt_vec_addr = win_vec;
               nxt_push_pc = pc_i;
               nxt_cnt = 2'h0;
               nxt_st = ST_ENT;
            end else if (sleep_i && glob_ff && any_pend && !blocked) begin
               nxt_cnt = 2'h0;
               nxt_st = ST_WAKE;
            end else if (op_i == OP_PUSH) begin
               nxt_mem = '{we: 1'b1, re: 1'b0, addr: {5'h00, sp_ff}, wdata: push_data_i};
               nxt_sp = sp_ff - SP_ONE;
            end else if (op_i == OP_POP) begin
               nxt_mem = '{we: 1'b0, re: 1'b1, addr: {5'h00, sp_ff + SP_ONE}, wdata: 8'h00};
               nxt_sp = sp_ff + SP_ONE;
            end else if (op_i == OP_CALL) begin
               nxt_push_pc = pc_i;
               nxt_cnt = 2'h0;
               nxt_st = ST_CALL;
            end else if (op_i == OP_RET || op_i == OP_RETURN_FROM_IRQ_INSTR) begin
               nxt_return_from_irq_instr = (op_i == OP_RETURN_FROM_IRQ_INSTR);
               nxt_cnt = 2'h0;
               nxt_st = ST_RET;
            end
         end
         ST_WAKE: begin
            nxt_cnt = cnt_ff + 2'h1;
            if (cnt_ff == WAKE_CYC) begin
               nxt_glob = 1'b0;
               nxt_flag = (nxt_flag & ~(win & FLAG_TYPE)) | irq_evt_i;
               nxt_vec_addr = win_vec;
               nxt_push_pc = pc_i;
               nxt_cnt = 2'h0;
               nxt_st = any_pend ? ST_ENT : ST_RUN;
            end
         end
         ST_ENT, ST_CALL: begin
            nxt_cnt = cnt_ff + 2'h1;
            if (cnt_ff < 2'h2) begin
               nxt_mem = '{we: 1'b1, re: 1'b0, addr: {5'h00, sp_ff},
                           wdata: cnt_ff[0] ? push_pc_ff[15:8] : push_pc_ff[7:0]};
               nxt_sp = sp_ff - SP_ONE;
            end
            if (st_ff == ST_CALL && cnt_ff == CALL_CYC) begin
               nxt_st = ST_RUN;
            end
            if (st_ff == ST_ENT && cnt_ff == ENT_CYC) begin
               nxt_vec_valid = 1'b1;
               nxt_st = ST_RUN;
            end
         end
         ST_RET: begin
            nxt_cnt = cnt_ff + 2'h1;
            if (cnt_ff < 2'h2) begin
               nxt_mem = '{we: 1'b0, re: 1'b1, addr: {5'h00, sp_ff + SP_ONE}, wdata: 8'h00};
               nxt_sp = sp_ff + SP_ONE;
            end
            // Read data stands one cycle after the registered read strobe
            if (cnt_ff == 2'h2) begin
               nxt_ret_pc[15:8] = mem_rdata_i;
            end
            if (cnt_ff == RET_CYC) begin
               nxt_ret_pc[7:0] = mem_rdata_i;
            end
            if (cnt_ff == RET_CYC) begin
               nxt_pc_load = 1'b1;
               nxt_glob = return_from_irq_instr_ff | glob_ff;
               nxt_st = ST_RUN;
            end
         end
         default: begin
            nxt_st = ST_RUN;
         end
      endcase
   end

   // Single clock domain, no divider anywhere on the core clock
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff <= ST_RUN;
         cnt_ff <= 2'h0;
         sp_ff <= SP_RESET;
         return_from_irq_instr_ff <= 1'b0;
         glob_ff <= 1'b0;
         flag_ff <= '0;
         mem_ff <= '0;
         vec_valid_ff <= 1'b0;
         vec_addr_ff <= 16'h0000;
         pc_load_ff <= 1'b0;
         ret_pc_ff <= 16'h0000;
         push_pc_ff <= 16'h0000;
         reset_vec_ff <= 16'h0000;
         io_rdata_ff <= 8'h00;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sp_ff <= nxt_sp;
         return_from_irq_instr_ff <= nxt_return_from_irq_instr;
         glob_ff <= nxt_glob;
         flag_ff <= nxt_flag;
         mem_ff <= nxt_mem;
         vec_valid_ff <= nxt_vec_valid;
         vec_addr_ff <= nxt_vec_addr;
         pc_load_ff <= nxt_pc_load;
         ret_pc_ff <= nxt_ret_pc;
         push_pc_ff <= nxt_push_pc;
         reset_vec_ff <= nxt_reset_vec;
         io_rdata_ff <= nxt_io_rdata;
      end
   end

   // Stall during the wake wait and the stacking sequences, so fetch overlaps in every ST_RUN cycle
   assign stall_o = (st_ff != ST_RUN);
   assign rd_a_o = rd_a_ff;
   assign rd_b_o = rd_b_ff;
   assign ds_rdata_o = ds_rdata_ff;
   assign ds_hit_o = ds_hit_ff;
   assign ptr_addr_o = ptr_addr_ff;
   assign io_rdata_o = io_rdata_ff;
   assign mem_o = mem_ff;
   assign vec_valid_o = vec_valid_ff;
   assign vec_addr_o = vec_addr_ff;
   assign pc_load_o = pc_load_ff;
   assign ret_pc_o = ret_pc_ff;
   assign reset_vec_o = reset_vec_ff;
   assign glob_irq_en_o = glob_ff;
   assign flags_o = flag_ff;
   assign sp_o = sp_ff;
endmodule

// ==== scic_core_monitor.sv ====
`timescale 1ns/100ps
module scic_core_monitor
   import scic_pkg::*;
(
   input  wire logic        mclk_i,        // Core clock
   input  wire logic        nrst_i,        // Reset, active low
   input  wire scic_op_e    op_i,          // Stack/enable operation
   input  wire logic        io_we_i,       // I/O write strobe
   input  wire logic        stall_o,       // Sequence running
   input  wire logic        pc_load_o,     // Return address load
   input  wire logic        vec_valid_o,   // Vector jump
   input  wire logic        glob_irq_en_o, // Global enable
   input  wire logic [10:0] sp_o           // Stack pointer
);
   default clocking mon_cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   // I/O writes may move the pointer too, so they are kept out of the antecedents
   wire idle = !stall_o && !io_we_i;

   a_push_dec: assert property (idle && op_i == OP_PUSH |=> sp_o == $past(sp_o) - SP_ONE)
      else $error("push did not lower the pointer by one");
   a_pop_inc: assert property (idle && op_i == OP_POP |=> sp_o == $past(sp_o) + SP_ONE)
      else $error("pop did not raise the pointer by one");
   a_call_dec: assert property (idle && op_i == OP_CALL |-> ##3 sp_o == $past(sp_o, 3) - SP_TWO)
      else $error("call did not lower the pointer by two");
   a_ret_inc: assert property (idle && op_i inside {OP_RET, OP_RETURN_FROM_IRQ_INSTR} |-> ##5 sp_o == $past(sp_o, 5) + SP_TWO)
      else $error("return did not raise the pointer by two");
   a_ret_load: assert property (idle && op_i inside {OP_RET, OP_RETURN_FROM_IRQ_INSTR} |-> ##5 pc_load_o)
      else $error("return address not loaded in the fourth cycle");
   a_return_from_irq_instr_glob_gap: assert property (idle && op_i == OP_RETURN_FROM_IRQ_INSTR |-> ##5 glob_irq_en_o && !stall_o)
      else $error("return from handler did not enable and run one instruction");
   a_irq_entry: assert property ($rose(stall_o) && $fell(glob_irq_en_o) |-> ##4 vec_valid_o && sp_o == $past(sp_o, 4) - SP_TWO)
      else $error("entry did not vector in four cycles with two bytes pushed");
   a_cli_block: assert property (idle && op_i == OP_CLI |=> !glob_irq_en_o && !stall_o)
      else $error("interrupt taken with the disable instruction");
   a_sei_next: assert property (idle && op_i == OP_SEI |=> glob_irq_en_o && !stall_o)
      else $error("enable instruction not followed by one instruction");
endmodule

bind scic_core scic_core_monitor scic_core_monitor_inst (
   .mclk_i        (mclk_i),
   .nrst_i        (nrst_i),
   .op_i          (op_i),
   .io_we_i       (io_we_i),
   .stall_o       (stall_o),
   .pc_load_o     (pc_load_o),
   .vec_valid_o   (vec_valid_o),
   .glob_irq_en_o (glob_irq_en_o),
   .sp_o          (sp_o)
);

// ==== scic_pkg.sv ====
package scic_pkg;
   // Register file and data space
   localparam int          RF_DEPTH    = 32;
   localparam int          RF_AW       = 5;
   localparam int          DA_W        = 16;
   localparam logic [4:0]  PTR_BASE    = 5'h1a;
   // Stack pointer
   localparam int          SP_W        = 11;
   localparam logic [5:0]  IO_SP_LOW   = 6'h3d;
   localparam logic [5:0]  IO_SP_HIGH  = 6'h3e;
   localparam logic [10:0] SP_RESET    = 11'h4ff;
   localparam logic [10:0] SP_ONE      = 11'h001;
   localparam logic [10:0] SP_TWO      = 11'h002;
   // Interrupt timing and vectors
   localparam logic [1:0]  ENT_CYC     = 2'h3;
   localparam logic [1:0]  RET_CYC     = 2'h3;
   localparam logic [1:0]  CALL_CYC    = 2'h1;
   localparam logic [1:0]  WAKE_CYC    = 2'h3;
   localparam logic [15:0] VEC_STEP    = 16'h0002;
   localparam logic [15:0] RESET_VEC   = 16'h0000;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_PUSH = 3'h1,
      OP_POP  = 3'h2,
      OP_CALL = 3'h3,
      OP_RET  = 3'h4,
      OP_RETURN_FROM_IRQ_INSTR = 3'h5,
      OP_CLI  = 3'h6,
      OP_SEI  = 3'h7
   } scic_op_e;

   typedef enum logic [1:0] {
      PM_DISP = 2'h0,
      PM_INC  = 2'h1,
      PM_DEC  = 2'h2
   } scic_pmode_e;

   typedef struct packed {
      logic [4:0]  ra;
      logic [4:0]  rb;
      logic        rd_wide;
      logic        we;
      logic        we_wide;
      logic [4:0]  wa;
      logic [15:0] wd;
   } scic_rf_req_s;

   typedef struct packed {
      logic        en;
      logic [1:0]  sel;
      scic_pmode_e mode;
      logic [5:0]  disp;
   } scic_ptr_req_s;

   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } scic_mem_s;
endpackage

// ==== scic_stack_mem.sv ====
`timescale 1ns/100ps
module scic_stack_mem
   import scic_pkg::*;
(
   input  wire logic      mclk_i,  // Core clock
   input  wire scic_mem_s mem_i,   // Stack access from the core
   output logic [7:0]     rdata_o  // Read data, cycle after read
);
   logic [7:0] mem [0:2047];

   always @(posedge mclk_i) begin
      if (mem_i.we) begin
         mem[mem_i.addr[10:0]] <= mem_i.wdata;
      end
      // Outside a read the bus flips so stale data never passes for an answer
      rdata_o <= mem_i.re ? mem[mem_i.addr[10:0]] : ~rdata_o;
   end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top
   import scic_pkg::*;
();
   logic          mclk   = 1'b0;
   logic          nrst   = 1'b0;
   scic_rf_req_s  rf     = '0;
   scic_ptr_req_s ptr    = '0;
   scic_mem_s     ds     = '0;
   scic_op_e      op     = OP_NONE;
   logic          io_we  = 1'b0;
   logic          io_re  = 1'b0;
   logic [5:0]    io_a   = 6'h00;
   logic [7:0]    io_wd  = 8'h00;
   logic [7:0]    push_d = 8'h00;
   logic [15:0]   pc     = 16'h0000;
   logic [7:0]    evt    = 8'h00;
   logic [7:0]    ien    = 8'h00;
   logic          fwe    = 1'b0;
   logic [7:0]    fdat   = 8'h00;
   logic          vts    = 1'b0;
   logic          fuse   = 1'b0;
   logic          alock  = 1'b0;
   logic [15:0]   bstart = 16'h0000;
   logic          done   = 1'b1;
   logic          slp    = 1'b0;
   logic [15:0]   rd_a, ptr_a, vaddr, ret_pc, rvec, got_vec, got_ret;
   logic [7:0]    rd_b, ds_rd, io_rd, mrd, flags;
   logic          ds_hit, stall, vvld, pld, glob;
   logic [10:0]   sp;
   scic_mem_s     mem;
   int            err_total = 0;
   int            cmp_count = 0;

   always #20 mclk = ~mclk;

   always @(posedge mclk) begin
      if (pld) got_ret <= ret_pc;
      if (vvld) got_vec <= vaddr;
   end

   scic_core scic_core_inst (
      .mclk_i(mclk), .nrst_i(nrst), .rf_req_i(rf), .rd_a_o(rd_a), .rd_b_o(rd_b),
      .ds_i(ds), .ds_rdata_o(ds_rd), .ds_hit_o(ds_hit), .ptr_req_i(ptr), .ptr_addr_o(ptr_a),
      .io_we_i(io_we), .io_re_i(io_re), .io_addr_i(io_a), .io_wdata_i(io_wd), .io_rdata_o(io_rd),
      .op_i(op), .push_data_i(push_d), .pc_i(pc), .instr_done_i(done), .sleep_i(slp),
      .mem_o(mem), .mem_rdata_i(mrd), .stall_o(stall), .vec_valid_o(vvld), .vec_addr_o(vaddr),
      .pc_load_o(pld), .ret_pc_o(ret_pc), .reset_vec_o(rvec), .glob_irq_en_o(glob),
      .flags_o(flags), .sp_o(sp), .irq_evt_i(evt), .irq_lvl_i(8'h00), .irq_en_i(ien),
      .flag_clr_we_i(fwe), .flag_clr_data_i(fdat), .vector_table_select_i(vts),
      .boot_reset_fuse_i(fuse), .app_section_lock_bit_i(alock),
      .boot_section_lock_bit_i(1'b0), .boot_start_i(bstart));

   scic_stack_mem scic_stack_mem_inst (.mclk_i(mclk), .mem_i(mem), .rdata_o(mrd));

   task nc;
      @(negedge mclk);
   endtask

   function logic [15:0] m(input int a);
      return 16'(scic_stack_mem_inst.mem[a]);
   endfunction

   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask

   task do_op(input scic_op_e o);
      nc;
      op = o;
      nc;
      op = OP_NONE;
      repeat (8) if (stall) nc;
      nc;
   endtask

   task io_wr(input logic [5:0] a, input logic [7:0] d);
      nc;
      io_a = a;
      io_wd = d;
      io_we = 1'b1;
      nc;
      io_we = 1'b0;
   endtask

   task io_rdb(input logic [5:0] a, output logic [7:0] d);
      nc;
      io_a = a;
      io_re = 1'b1;
      nc;
      io_re = 1'b0;
      d = io_rd;
   endtask

   task t_reset;
      logic [7:0] v;
      chk("sp", 16'(sp), 16'(SP_RESET));
      chk("glob", 16'(glob), 16'h0000);
      io_rdb(IO_SP_LOW, v);
      chk("sp_low", 16'(v), 16'(SP_RESET[7:0]));
      io_rdb(IO_SP_HIGH, v);
      chk("sp_high", 16'(v), 16'(SP_RESET[10:8]));
      chk("rvec", rvec, RESET_VEC);
      $display("test reset finished");
   endtask

   task t_regs;
      nc;
      rf = '{ra: 5'h1a, rb: 5'h1b, rd_wide: 1'b0, we: 1'b1, we_wide: 1'b1, wa: 5'h1a, wd: 16'h0010};
      nc;
      rf.we = 1'b0;
      rf.rd_wide = 1'b1;
      nc;
      chk("rd_wide", rd_a, 16'h0010);
      chk("rd_b", 16'(rd_b), 16'h0000);
      rf = '{ra: 5'h06, rb: 5'h00, rd_wide: 1'b0, we: 1'b1, we_wide: 1'b0, wa: 5'h05, wd: 16'h00a5};
      nc;
      rf.we = 1'b0;
      ds = '{we: 1'b0, re: 1'b1, addr: 16'h0005, wdata: 8'h00};
      nc;
      chk("ds_rd", 16'(ds_rd), 16'h00a5);
      chk("ds_hit", 16'(ds_hit), 16'h0001);
      ds = '{we: 1'b1, re: 1'b0, addr: 16'h0006, wdata: 8'h3c};
      nc;
      ds.we = 1'b0;
      nc;
      chk("rd_ds", rd_a, 16'h003c);
      ptr = '{en: 1'b1, sel: 2'h0, mode: PM_INC, disp: 6'h00};
      nc;
      chk("ptr_inc", ptr_a, 16'h0010);
      ptr.mode = PM_DEC;
      nc;
      chk("ptr_dec", ptr_a, 16'h0010);
      ptr.mode = PM_DISP;
      ptr.disp = 6'h05;
      nc;
      chk("ptr_disp", ptr_a, 16'h0015);
      ptr.en = 1'b0;
      $display("test regs finished");
   endtask

   task t_stack;
      io_wr(IO_SP_HIGH, 8'h01);
      io_wr(IO_SP_LOW, 8'h00);
      chk("sp_io", 16'(sp), 16'h0100);
      push_d = 8'h5a;
      do_op(OP_PUSH);
      chk("sp_push", 16'(sp), 16'h00ff);
      chk("push_mem", m(256), 16'h005a);
      do_op(OP_POP);
      chk("sp_pop", 16'(sp), 16'h0100);
      pc = 16'h1234;
      do_op(OP_CALL);
      chk("sp_call", 16'(sp), 16'h00fe);
      chk("call_lo", m(256), 16'h0034);
      chk("call_hi", m(255), 16'h0012);
      do_op(OP_RET);
      chk("ret_pc", got_ret, 16'h1234);
      chk("sp_ret", 16'(sp), 16'h0100);
      $display("test stack finished");
   endtask

   task t_irq;
      got_vec = 16'h0000;
      ien = 8'h0a;
      nc;
      evt = 8'h0a;
      nc;
      evt = 8'h00;
      repeat (3) nc;
      chk("flags_pend", 16'(flags), 16'h000a);
      chk("no_take", got_vec, 16'h0000);
      pc = 16'h0200;
      do_op(OP_SEI);
      repeat (8) nc;
      chk("vec_hi", got_vec, 16'h0004);
      chk("flag_hw", 16'(flags), 16'h0008);
      chk("glob_clr", 16'(glob), 16'h0000);
      chk("sp_entry", 16'(sp), 16'h00fe);
      chk("entry_lo", m(256), 16'h0000);
      chk("entry_hi", m(255), 16'h0002);
      do_op(OP_RETURN_FROM_IRQ_INSTR);
      repeat (8) nc;
      chk("return_from_irq_instr_pc", got_ret, 16'h0200);
      chk("vec_next", got_vec, 16'h0008);
      chk("flags_none", 16'(flags), 16'h0000);
      do_op(OP_RETURN_FROM_IRQ_INSTR);
      chk("glob_set", 16'(glob), 16'h0001);
      chk("sp_return_from_irq_instr", 16'(sp), 16'h0100);
      got_vec = 16'h0000;
      nc;
      op = OP_CLI;
      evt = 8'h02;
      nc;
      op = OP_NONE;
      evt = 8'h00;
      repeat (6) nc;
      chk("cli_block", got_vec, 16'h0000);
      chk("cli_flag", 16'(flags), 16'h0002);
      fdat = 8'h02;
      fwe = 1'b1;
      nc;
      fwe = 1'b0;
      nc;
      chk("flag_sw", 16'(flags), 16'h0000);
      $display("test irq finished");
   endtask

   task t_reloc;
      vts = 1'b1;
      fuse = 1'b1;
      bstart = 16'h1000;
      ien = 8'h01;
      alock = 1'b1;
      got_vec = 16'h0000;
      nc;
      evt = 8'h01;
      nc;
      evt = 8'h00;
      chk("rvec_boot", rvec, 16'h1000);
      do_op(OP_SEI);
      repeat (6) nc;
      chk("lock_block", got_vec, 16'h0000);
      chk("lock_flag", 16'(flags), 16'h0001);
      alock = 1'b0;
      repeat (8) nc;
      chk("vec_boot", got_vec, 16'h1002);
      do_op(OP_RETURN_FROM_IRQ_INSTR);
      // Asleep mid-instruction: four wake cycles come before the four entry cycles
      got_vec = 16'h0000;
      done = 1'b0;
      slp = 1'b1;
      evt = 8'h01;
      nc;
      evt = 8'h00;
      repeat (8) nc;
      chk("wake_wait", got_vec, 16'h0000);
      repeat (2) nc;
      chk("wake_vec", got_vec, 16'h1002);
      slp = 1'b0;
      done = 1'b1;
      do_op(OP_RETURN_FROM_IRQ_INSTR);
      $display("test reloc finished");
   endtask

   task end_sim;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (3) nc;
      nrst = 1'b1;
      nc;
      t_reset;
      t_regs;
      t_stack;
      t_irq;
      t_reloc;
      end_sim;
   end

   // The tests need about 130 cycles; this limit only cuts a hang
   initial begin
      repeat (2000) @(posedge mclk);
      err_total++;
      $display("watchdog expired");
      end_sim;
   end
endmodule
